// *** design/fop_pkg.sv ***
// constants and types for the field octet packer
// Operation
// - field bit zero into lowest unfilled bit
// - next field bits fill next higher positions
// - full octet continues into next octet
// - fields packed in order without gaps
// - groups packed in order as subfields
// - zero-pad unused bits of last octet
// - each message starts a fresh octet
// - octets numbered sequentially from zero
// - serial out in index order, LSB first
// - LSB means unit-weight bit
package fop_pkg;
	localparam int FIELD_W = 32;
	localparam int LEN_W = 6;
	localparam int IDX_W = 16;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [LEN_W-1:0] LEN_ZERO = 6'h00;
	localparam logic [LEN_W-1:0] LEN_ONE = 6'h01;
	localparam logic [IDX_W-1:0] IDX_FIRST = 16'h0000;
	localparam logic [IDX_W-1:0] IDX_ONE = 16'h0001;
	localparam logic [7:0] OCTET_ZERO = 8'h00;
	typedef enum logic [2:0] {
		FOP_IDLE = 3'b001,
		FOP_PACK = 3'b010,
		FOP_SEND = 3'b100
	} fop_state_t;
endpackage : fop_pkg

// *** design/fop_serializer.sv ***
// octet to serial bit stream, lowest-weight bit first
module fop_serializer (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic [7:0] octet,
	output logic busy,
	output logic ser_valid,
	output logic ser_bit
);
	logic [7:0] shreg;
	logic [2:0] cnt;
	logic next_busy;
	assign next_busy = load | (busy & (cnt != fop_pkg::BIT_LAST));
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shreg <= fop_pkg::OCTET_ZERO;
			cnt <= fop_pkg::BIT_FIRST;
			busy <= 1'b0;
			ser_valid <= 1'b0;
			ser_bit <= 1'b0;
		end else begin
			busy <= next_busy;
			ser_valid <= load | busy & (cnt != fop_pkg::BIT_LAST);
			if (load) begin
				shreg <= {1'b0, octet[7:1]};
				ser_bit <= octet[0];
				cnt <= fop_pkg::BIT_FIRST;
			end else if (busy) begin
				shreg <= {1'b0, shreg[7:1]};
				ser_bit <= shreg[0];
				cnt <= cnt + 3'h1;
			end
		end
	end
endmodule : fop_serializer

// *** design/fop_packer.sv ***
// field octet packer top: fills octets LSB first, emits numbered octets and serial bits
module fop_packer (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic fld_valid,
	output logic fld_ready,
	input wire logic [fop_pkg::FIELD_W-1:0] fld_data,
	input wire logic [fop_pkg::LEN_W-1:0] fld_len,
	input wire logic fld_last,
	output logic oct_valid,
	output logic [7:0] oct_data,
	output logic [fop_pkg::IDX_W-1:0] oct_index,
	output logic oct_last,
	output logic ser_valid,
	output logic ser_bit
);
	fop_pkg::fop_state_t state;
	logic [fop_pkg::FIELD_W-1:0] shreg;
	logic [fop_pkg::LEN_W-1:0] remain;
	logic msg_last;
	logic [7:0] acc;
	logic [2:0] pos;
	logic [fop_pkg::IDX_W-1:0] next_idx;
	logic [7:0] send_octet;
	logic send_last;
	logic ser_busy;
	logic ser_load;

	// ----------------------------------------
	// bit placement
	// ----------------------------------------
	wire last_bit = (remain == fop_pkg::LEN_ONE);
	wire octet_full = (pos == fop_pkg::BIT_LAST);
	// current bit placed in lowest unfilled position, bits above cleared
	wire [7:0] placed = (acc & ~(8'hFF << pos)) | ({7'h00, shreg[0]} << pos);
	wire emit = (state == fop_pkg::FOP_PACK) && (octet_full || (last_bit && msg_last));
	wire take = fld_ready & fld_valid;
	wire zero_len = take & (fld_len == fop_pkg::LEN_ZERO);
	// empty last field with a partial octet still must flush
	wire flush = zero_len & fld_last & (pos != fop_pkg::BIT_FIRST);
	assign ser_load = (state == fop_pkg::FOP_SEND) & ~ser_busy;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= fop_pkg::FOP_IDLE;
			fld_ready <= 1'b0;
			shreg <= '0;
			remain <= fop_pkg::LEN_ZERO;
			msg_last <= 1'b0;
			acc <= fop_pkg::OCTET_ZERO;
			pos <= fop_pkg::BIT_FIRST;
			next_idx <= fop_pkg::IDX_FIRST;
			send_octet <= fop_pkg::OCTET_ZERO;
			send_last <= 1'b0;
			oct_valid <= 1'b0;
			oct_data <= fop_pkg::OCTET_ZERO;
			oct_index <= fop_pkg::IDX_FIRST;
			oct_last <= 1'b0;
		end else begin
			oct_valid <= 1'b0;
			case (state)
				fop_pkg::FOP_IDLE: begin
					fld_ready <= 1'b1;
					if (take && fld_len != fop_pkg::LEN_ZERO) begin
						fld_ready <= 1'b0;
						shreg <= fld_data;
						remain <= fld_len;
						msg_last <= fld_last;
						state <= fop_pkg::FOP_PACK;
					end else if (flush) begin
						fld_ready <= 1'b0;
						send_octet <= acc & ~(8'hFF << pos);
						send_last <= 1'b1;
						acc <= fop_pkg::OCTET_ZERO;
						pos <= fop_pkg::BIT_FIRST;
						state <= fop_pkg::FOP_SEND;
					end else if (zero_len && fld_last) begin
						next_idx <= fop_pkg::IDX_FIRST;
					end
				end
				fop_pkg::FOP_PACK: begin
					shreg <= shreg >> 1;
					remain <= remain - fop_pkg::LEN_ONE;
					if (emit) begin
						send_octet <= placed;
						send_last <= last_bit & msg_last;
						acc <= fop_pkg::OCTET_ZERO;
						pos <= fop_pkg::BIT_FIRST;
						state <= fop_pkg::FOP_SEND;
					end else begin
						acc <= placed;
						pos <= pos + 3'h1;
						if (last_bit) begin
							state <= fop_pkg::FOP_IDLE;
						end
					end
				end
				fop_pkg::FOP_SEND: begin
					if (ser_load) begin
						oct_valid <= 1'b1;
						oct_data <= send_octet;
						oct_index <= next_idx;
						oct_last <= send_last;
						next_idx <= send_last ? fop_pkg::IDX_FIRST : next_idx + fop_pkg::IDX_ONE;
						if (remain == fop_pkg::LEN_ZERO) begin
							state <= fop_pkg::FOP_IDLE;
						end else begin
							state <= fop_pkg::FOP_PACK;
						end
					end
				end
				default: begin
					state <= fop_pkg::FOP_IDLE;
					fld_ready <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// serial output
	// ----------------------------------------
	fop_serializer u_ser (
		.clk(clk),
		.sys_rst(sys_rst),
		.load(ser_load),
		.octet(send_octet),
		.busy(ser_busy),
		.ser_valid(ser_valid),
		.ser_bit(ser_bit)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_first_bit_low;
		@(posedge clk) disable iff (sys_rst)
		(state == fop_pkg::FOP_IDLE && take && fld_len != fop_pkg::LEN_ZERO && pos == 3'h0)
		|=> ##1 (acc[0] == $past(fld_data[0], 2) || state == fop_pkg::FOP_SEND);
	endproperty
	a_first_bit_low: assert property (p_first_bit_low) else $error("field bit zero misplaced");

	property p_pos_step;
		@(posedge clk) disable iff (sys_rst)
		(state == fop_pkg::FOP_PACK && !emit) |=> (pos == $past(pos) + 3'h1);
	endproperty
	a_pos_step: assert property (p_pos_step) else $error("fill position did not advance");

	property p_full_emits;
		@(posedge clk) disable iff (sys_rst)
		(state == fop_pkg::FOP_PACK && octet_full) |=> (state == fop_pkg::FOP_SEND && pos == 3'h0);
	endproperty
	a_full_emits: assert property (p_full_emits) else $error("full octet not released");

	property p_no_take_busy;
		@(posedge clk) disable iff (sys_rst)
		(state != fop_pkg::FOP_IDLE) |-> !fld_ready;
	endproperty
	a_no_take_busy: assert property (p_no_take_busy) else $error("field taken out of order");

	property p_pad_zero;
		@(posedge clk) disable iff (sys_rst)
		(emit && !octet_full) |=> ((send_octet >> ($past(pos) + 3'h1)) == 8'h00);
	endproperty
	a_pad_zero: assert property (p_pad_zero) else $error("padding not zero");

	property p_fresh_msg;
		@(posedge clk) disable iff (sys_rst)
		(oct_valid && oct_last) |-> (pos == 3'h0);
	endproperty
	a_fresh_msg: assert property (p_fresh_msg) else $error("message not on fresh octet");

	property p_index_seq;
		@(posedge clk) disable iff (sys_rst)
		oct_valid |-> (next_idx == (oct_last ? fop_pkg::IDX_FIRST : oct_index + fop_pkg::IDX_ONE));
	endproperty
	a_index_seq: assert property (p_index_seq) else $error("octet index broken");

	property p_ser_lsb;
		@(posedge clk) disable iff (sys_rst)
		ser_load |=> (ser_valid && ser_bit == $past(send_octet[0]));
	endproperty
	a_ser_lsb: assert property (p_ser_lsb) else $error("serial not lsb first");

	// ----------------------------------------
	// check helpers: octet under serial send
	// ----------------------------------------
	logic [7:0] chk_octet;
	logic [2:0] chk_cnt;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			chk_octet <= fop_pkg::OCTET_ZERO;
			chk_cnt <= fop_pkg::BIT_FIRST;
		end else if (ser_load) begin
			chk_octet <= send_octet;
			chk_cnt <= fop_pkg::BIT_FIRST;
		end else if (ser_valid) begin
			chk_cnt <= chk_cnt + 3'h1;
		end
	end

	property p_shift_feed;
		@(posedge clk) disable iff (sys_rst)
		(state == fop_pkg::FOP_PACK) |=> (shreg == ($past(shreg) >> 1));
	endproperty
	a_shift_feed: assert property (p_shift_feed) else $error("field not shifted");

	property p_remain_dec;
		@(posedge clk) disable iff (sys_rst)
		(state == fop_pkg::FOP_PACK) |=> (remain == $past(remain) - fop_pkg::LEN_ONE);
	endproperty
	a_remain_dec: assert property (p_remain_dec) else $error("bit count not stepped");

	property p_oct_pulse;
		@(posedge clk) disable iff (sys_rst)
		oct_valid |=> !oct_valid;
	endproperty
	a_oct_pulse: assert property (p_oct_pulse) else $error("octet strobe too long");

	property p_ser_run;
		@(posedge clk) disable iff (sys_rst)
		ser_load |=> ser_valid [*8] ##1 !ser_valid;
	endproperty
	a_ser_run: assert property (p_ser_run) else $error("serial run not eight bits");

	property p_ser_order;
		@(posedge clk) disable iff (sys_rst)
		ser_valid |-> (ser_bit == chk_octet[chk_cnt]);
	endproperty
	a_ser_order: assert property (p_ser_order) else $error("serial bit out of order");

	property p_par_ser_same;
		@(posedge clk) disable iff (sys_rst)
		oct_valid |-> (oct_data == chk_octet);
	endproperty
	a_par_ser_same: assert property (p_par_ser_same) else $error("octet and serial differ");

	property p_last_idle;
		@(posedge clk) disable iff (sys_rst)
		(oct_valid && oct_last) |-> (state == fop_pkg::FOP_IDLE);
	endproperty
	a_last_idle: assert property (p_last_idle) else $error("message end not idle");

	property p_flush_pad;
		@(posedge clk) disable iff (sys_rst)
		flush |=> ((send_octet >> $past(pos)) == fop_pkg::OCTET_ZERO);
	endproperty
	a_flush_pad: assert property (p_flush_pad) else $error("flush padding not zero");

	property p_zero_len;
		@(posedge clk) disable iff (sys_rst)
		zero_len |=> (state != fop_pkg::FOP_PACK);
	endproperty
	a_zero_len: assert property (p_zero_len) else $error("empty field packed bits");

	property p_send_wait;
		@(posedge clk) disable iff (sys_rst)
		(state == fop_pkg::FOP_SEND && ser_busy) |=> (state == fop_pkg::FOP_SEND);
	endproperty
	a_send_wait: assert property (p_send_wait) else $error("octet released while busy");

	property p_take_loads;
		@(posedge clk) disable iff (sys_rst)
		(take && fld_len != fop_pkg::LEN_ZERO) |=> (state == fop_pkg::FOP_PACK
			&& shreg == $past(fld_data) && remain == $past(fld_len));
	endproperty
	a_take_loads: assert property (p_take_loads) else $error("field not loaded");

	property p_no_gap;
		@(posedge clk) disable iff (sys_rst)
		(state == fop_pkg::FOP_PACK && !emit && last_bit) |=> (state == fop_pkg::FOP_IDLE
			&& pos == $past(pos) + 3'h1);
	endproperty
	a_no_gap: assert property (p_no_gap) else $error("gap after field");

	property p_idle_hold;
		@(posedge clk) disable iff (sys_rst)
		(state == fop_pkg::FOP_IDLE && !take) |=> (pos == $past(pos) && acc == $past(acc));
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("partial octet lost");

	property p_oct_hold;
		@(posedge clk) disable iff (sys_rst)
		1'b1 |=> (oct_valid || ($stable(oct_data) && $stable(oct_index)));
	endproperty
	a_oct_hold: assert property (p_oct_hold) else $error("octet outputs not held");

	property p_ready_back;
		@(posedge clk) disable iff (sys_rst)
		(state == fop_pkg::FOP_IDLE && !fld_ready) |=> fld_ready;
	endproperty
	a_ready_back: assert property (p_ready_back) else $error("ready not restored");

	property p_busy_len;
		@(posedge clk) disable iff (sys_rst)
		$rose(ser_busy) |-> ser_busy [*8] ##1 !ser_busy;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("serializer busy length");

	property p_end_marks;
		@(posedge clk) disable iff (sys_rst)
		(emit && last_bit && msg_last) |=> send_last;
	endproperty
	a_end_marks: assert property (p_end_marks) else $error("final octet not marked");

	property p_acc_clear;
		@(posedge clk) disable iff (sys_rst)
		emit |=> (acc == fop_pkg::OCTET_ZERO);
	endproperty
	a_acc_clear: assert property (p_acc_clear) else $error("next octet not cleared");
endmodule : fop_packer

// *** verification/fop_source.sv ***
// message source model presenting fields to the packer
module fop_source (
	input wire logic clk,
	output logic fld_valid,
	input wire logic fld_ready,
	output logic [fop_pkg::FIELD_W-1:0] fld_data,
	output logic [fop_pkg::LEN_W-1:0] fld_len,
	output logic fld_last
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		fld_valid = 1'b0;
		fld_data = 32'h0000_0000;
		fld_len = 6'h00;
		fld_last = 1'b0;
	end
	// one field, held until taken; gap of at least one cycle keeps accepts apart
	task put(input logic [5:0] len, input logic [31:0] dat, input logic last, input int gap,
		output bit ok);
		repeat (gap) @(negedge clk);
		fld_len = len;
		fld_data = dat;
		fld_last = last;
		fld_valid = 1'b1;
		ok = 1'b0;
		for (int i = 0; i < 200 && !ok; i++) begin
			@(posedge clk);
			ok = (fld_ready === 1'b1);
		end
		@(negedge clk);
		fld_valid = 1'b0;
		// released lines carry junk, not the last value
		fld_data = ~dat;
		fld_len = ~len;
		fld_last = ~last;
	endtask : put
endmodule : fop_source

// *** verification/tb.sv ***
// self-checking bench for the field octet packer
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic fld_valid, fld_ready, fld_last, oct_valid, oct_last, ser_valid, ser_bit;
	logic [31:0] fld_data;
	logic [5:0] fld_len;
	logic [7:0] oct_data;
	logic [15:0] oct_index;
	int error_cnt = 0;
	int n_tests = 0;
	logic [7:0] exp_q[$];
	logic [7:0] got_q[$];
	logic [15:0] idx_q[$];
	logic last_q[$];
	logic bit_q[$];
	always #20 clk = ~clk;
	fop_source src (.clk(clk), .fld_valid(fld_valid), .fld_ready(fld_ready),
		.fld_data(fld_data), .fld_len(fld_len), .fld_last(fld_last));
	fop_packer dut (.clk(clk), .sys_rst(sys_rst), .fld_valid(fld_valid),
		.fld_ready(fld_ready), .fld_data(fld_data), .fld_len(fld_len), .fld_last(fld_last),
		.oct_valid(oct_valid), .oct_data(oct_data), .oct_index(oct_index),
		.oct_last(oct_last), .ser_valid(ser_valid), .ser_bit(ser_bit));
	always @(negedge clk) begin
		if (oct_valid === 1'b1) begin
			got_q.push_back(oct_data);
			idx_q.push_back(oct_index);
			last_q.push_back(oct_last);
		end
		if (ser_valid === 1'b1) bit_q.push_back(ser_bit);
	end
	task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task end_of_test;
		if (error_cnt == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_of_test
	task f(input logic [5:0] len, input logic [31:0] dat, input logic last, input int gap);
		bit ok;
		src.put(len, dat, last, gap, ok);
		chk("field taken", 16'(ok), 16'h0001);
		if (!ok) end_of_test();
	endtask : f
	task check_msg;
		logic [7:0] b;
		int k;
		k = 0;
		while (bit_q.size() < 8 * exp_q.size() && k < 600) begin
			@(negedge clk);
			k++;
		end
		chk("serial done", 16'(k < 600), 16'h0001);
		if (k >= 600) end_of_test();
		chk("octet count", 16'(got_q.size()), 16'(exp_q.size()));
		foreach (exp_q[i]) begin
			chk("octet", 16'(got_q[i]), 16'(exp_q[i]));
			chk("index", idx_q[i], 16'(i));
			chk("last", 16'(last_q[i]), 16'(i == exp_q.size() - 1));
			for (int j = 0; j < 8; j++) b[j] = bit_q[8 * i + j];
			chk("serial", 16'(b), 16'(exp_q[i]));
		end
		exp_q = {};
		got_q = {};
		idx_q = {};
		last_q = {};
		bit_q = {};
	endtask : check_msg
	// fields with cleared presence flags omitted, group fields sent one by one
	task t_table;
		f(6'h03, 32'h0000_0000, 1'b0, 1);
		f(6'h03, 32'h0000_0001, 1'b0, 1);
		f(6'h01, 32'h0000_0001, 1'b0, 4);
		f(6'h07, 32'h0000_0041, 1'b0, 1);
		f(6'h07, 32'h0000_0042, 1'b0, 2);
		f(6'h0E, 32'h0000_0607, 1'b0, 1);
		f(6'h01, 32'h0000_0000, 1'b0, 1);
		f(6'h01, 32'h0000_0000, 1'b0, 3);
		f(6'h01, 32'h0000_0000, 1'b1, 1);
		exp_q = {8'hC8, 8'hA0, 8'hF0, 8'hC0, 8'h00};
		check_msg();
	endtask : t_table
	// full-width field spread over five octets, zero-length flush
	task t_spill;
		f(6'h04, 32'h0000_000F, 1'b0, 1);
		f(6'h20, 32'h89AB_CDEF, 1'b0, 1);
		f(6'h00, 32'h0000_0000, 1'b1, 2);
		exp_q = {8'hFF, 8'hDE, 8'hBC, 8'h9A, 8'h08};
		check_msg();
	endtask : t_spill
	// short message right after another: fresh octet, index back to zero
	task t_short;
		f(6'h03, 32'h0000_0005, 1'b1, 1);
		exp_q = {8'h05};
		check_msg();
	endtask : t_short
	initial begin
		repeat (4) @(negedge clk);
		chk("reset outputs", {13'h0000, oct_valid, ser_valid, fld_ready}, 16'h0000);
		sys_rst = 1'b0;
		t_table();
		t_short();
		t_spill();
		t_short();
		end_of_test();
	end
endmodule : tb
